// ==== fbio_regs.svh ====
// constants for the fieldbus digital i/o output safety control block
// assumes inclusion by bare name from the package and design files
`ifndef FBIO_REGS_SVH
`define FBIO_REGS_SVH
`define CH_NUM 16
`define PRM_BYTE_W 8
`define FB_MODE_LSB 0
`define FB_MODE_MSB 1
`define IM0_MAKER_CODE 16'h1234 // arbitrary value
`define IM0_PROFILE_CODE 16'hF600
`define IM0_PROFILE_SUBTYPE 16'h0003
`define IM0_CHANGE_COUNT 16'h0000
`define IM0_RECORD_VERSION 16'h0102
`define IM0_RECORDS_PRESENT 16'h000E
`define IM_BLANK_BYTE 8'h20
`define IM_ZERO_BYTE 8'h00
`define IM_LEN_FUNC_TAG 32
`define IM_LEN_LOC_TAG 22
`define IM_LEN_DATE 16
`define IM_LEN_RSVD 38
`define IM_LEN_NOTE 54
`define IM_REC_LEN 64
`define IM_ADDR_W 6
`define DIAG_NUM 5
`define WD_CNT_W 24
`define WD_CNT_ONE 24'h000001
`define WD_CNT_ZERO 24'h000000
`endif

// ==== fbio_pkg.sv ====
// types shared by the fieldbus i/o control block
// assumes fbio_regs.svh is on the include path
`include "fbio_regs.svh"
package fbio_pkg;
   // fallback choice taken from the first module parameter byte
   typedef enum logic [1:0] {FB_ALL_LOW = 2'h0, FB_ALL_HIGH = 2'h1, FB_HOLD = 2'h2, FB_SUBST = 2'h3} fallback_t;
   typedef enum logic [1:0] {WD_OFF, WD_IDLE, WD_RUN, WD_EXPIRED} wd_state_t;
endpackage : fbio_pkg

// ==== fbio_if.sv ====
// carrier between the top module and the identification record store
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
`default_nettype none
`include "fbio_regs.svh"
interface im_store_if;
   logic [1:0] rec_sel;
   logic [`IM_ADDR_W-1:0] addr;
   logic wr_en;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   modport master (output rec_sel, output addr, output wr_en, output wr_data, input rd_data);
   modport slave (input rec_sel, input addr, input wr_en, input wr_data, output rd_data);
endinterface : im_store_if
`default_nettype wire

// ==== fbio_im_store.sv ====
// ==========================================================
// writable identification records one to three, byte addressed
// assumes reset already synchronised by the top module
`timescale 1ns/1ps
`default_nettype none
`include "fbio_regs.svh"
module fbio_im_store
(
   input wire logic mclk_i,
   input wire logic rst_n,
   im_store_if.slave bus
);
   logic [7:0] rec1_r [`IM_REC_LEN];
   logic [7:0] rec2_r [`IM_REC_LEN];
   logic [7:0] rec3_r [`IM_REC_LEN];
   logic [7:0] rd_nxt;

   // reset contents: blank text, zero reserved area
   function automatic logic [7:0] dflt(input int rec, input int idx);
      if (rec == 1)
         dflt = (idx < `IM_LEN_FUNC_TAG + `IM_LEN_LOC_TAG) ? `IM_BLANK_BYTE : `IM_ZERO_BYTE;
      else if (rec == 2)
         dflt = (idx < `IM_LEN_DATE) ? `IM_BLANK_BYTE : `IM_ZERO_BYTE;
      else
         dflt = (idx < `IM_LEN_NOTE) ? `IM_BLANK_BYTE : `IM_ZERO_BYTE;
   endfunction : dflt

   // one generated byte cell per record slot
   genvar g;
   generate
      for (g = 0; g < `IM_REC_LEN; g++)
      begin : g_cell
         logic hit;
         assign hit = bus.wr_en && (bus.addr == `IM_ADDR_W'(g));
         always_ff @(posedge mclk_i or negedge rst_n)
         begin
            if (!rst_n)
            begin
               rec1_r[g] <= dflt(1, g);
               rec2_r[g] <= dflt(2, g);
               rec3_r[g] <= dflt(3, g);
            end
            else
            begin
               if (hit && bus.rec_sel == 2'h1)
                  rec1_r[g] <= bus.wr_data;
               if (hit && bus.rec_sel == 2'h2)
                  rec2_r[g] <= bus.wr_data;
               if (hit && bus.rec_sel == 2'h3)
                  rec3_r[g] <= bus.wr_data;
            end
         end
      end
   endgenerate

   // read mux; the top module registers it so its output stays a flop
   always_comb
   begin
      unique case (bus.rec_sel)
         2'h1: rd_nxt = rec1_r[bus.addr];
         2'h2: rd_nxt = rec2_r[bus.addr];
         2'h3: rd_nxt = rec3_r[bus.addr];
         default: rd_nxt = `IM_ZERO_BYTE;
      endcase
   end

   assign bus.rd_data = rd_nxt;
endmodule : fbio_im_store
`default_nettype wire

// ==== fbio_ctrl.sv ====
// fieldbus digital i/o output safety control
// assumes the bus engine presents parameters, strobes and record accesses synchronous to mclk_i
//
// Overview of operation
// - parameter byte three gives substitute values for channels nine to sixteen.
// - parameter byte two gives substitute values for channels one to eight.
// - byte one bits 1:0 pick low, high, hold last, or per-channel substitute.
// - a channel used as output reports its state in input data.
// - record 0 holds maker, catalogue, serial, board and firmware fields, read only.
// - record 0 reports profile code F600 and subtype 0003.
// - record 0 reports change count 0000, version 0102, records present 000E.
// - record 1 holds writable function and location tags, blank by default.
// - record 2 holds writable install date, blank, and zero reserved bytes.
// - record 3 holds a writable 54-byte note, blank by default.
// - sync command latches output data and holds it until next sync.
// - freeze command snapshots inputs and reports them until next freeze.
// - alarms enabled after reset; startup parameters may disable them.
// - incoming alarm when entry stored, outgoing alarm when entry removed.
// - sum fault indicator on while any diagnostic entry is stored.
// - entries for overtemperature, supply surge, supply overload, short, overload.
// - watchdog starts on first output write, restarts on each later write.
// - reads of process data never restart the watchdog.
// - timeout forces substitute values and lights the bus fault indicator.
// - communication loss or no valid output data applies substitute values.
`timescale 1ns/1ps
`default_nettype none
`include "fbio_regs.svh"
module fbio_ctrl
#(
   parameter logic [159:0] CATALOGUE_NUMBER = '0, // arbitrary value
   parameter logic [127:0] UNIT_SERIAL = '0, // arbitrary value
   parameter logic [15:0] BOARD_REV = 16'h0001, // arbitrary value
   parameter logic [31:0] FIRMWARE_REV = 32'h00000001 // arbitrary value
)
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [`PRM_BYTE_W-1:0] prm_behavior_i,
   input wire logic [`PRM_BYTE_W-1:0] prm_subst_lo_i,
   input wire logic [`PRM_BYTE_W-1:0] prm_subst_hi_i,
   input wire logic prm_load_i,
   input wire logic prm_sync_freeze_en_i,
   input wire logic prm_alarm_dis_i,
   input wire logic prm_wd_en_i,
   input wire logic [`WD_CNT_W-1:0] prm_wd_period_i,
   input wire logic [`CH_NUM-1:0] out_data_i,
   input wire logic out_wr_i,
   input wire logic in_rd_i,
   input wire logic out_valid_i,
   input wire logic comm_ok_i,
   input wire logic sync_cmd_i,
   input wire logic freeze_cmd_i,
   input wire logic [`CH_NUM-1:0] pin_in_i,
   input wire logic [`CH_NUM-1:0] ch_is_out_i,
   input wire logic [`DIAG_NUM-1:0] diag_cond_i,
   input wire logic [1:0] im_rec_i,
   input wire logic [`IM_ADDR_W-1:0] im_addr_i,
   input wire logic im_wr_i,
   input wire logic [7:0] im_wdata_i,
   output logic [7:0] im_rdata_o,
   output logic [`CH_NUM-1:0] pin_out_o,
   output logic [`CH_NUM-1:0] in_data_o,
   output logic alarm_in_o,
   output logic alarm_out_o,
   output logic sum_fault_indicator_o,
   output logic bus_fault_indicator_o
);
   // ==========================================================
   // reset release
   logic rst_m_r;
   logic rst_n;
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_m_r <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_m_r <= 1'b1;
         rst_n <= rst_m_r;
      end
   end

   // ==========================================================
   // parameter capture
   logic [1:0] mode_r, mode_nxt;
   logic [`CH_NUM-1:0] subst_r, subst_nxt;
   logic sf_en_r, sf_en_nxt;
   logic alarm_en_r, alarm_en_nxt;

   always_comb
   begin
      mode_nxt = mode_r;
      subst_nxt = subst_r;
      sf_en_nxt = sf_en_r;
      alarm_en_nxt = alarm_en_r;
      if (prm_load_i)
      begin
         mode_nxt = prm_behavior_i[`FB_MODE_MSB:`FB_MODE_LSB];
         subst_nxt = {prm_subst_hi_i, prm_subst_lo_i};
         sf_en_nxt = prm_sync_freeze_en_i;
         alarm_en_nxt = !prm_alarm_dis_i;
      end
   end

   // alarms on by default out of reset
   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_r <= 2'h0;
         subst_r <= 16'h0000;
         sf_en_r <= 1'b0;
         alarm_en_r <= 1'b1;
      end
      else
      begin
         mode_r <= mode_nxt;
         subst_r <= subst_nxt;
         sf_en_r <= sf_en_nxt;
         alarm_en_r <= alarm_en_nxt;
      end
   end

   // ==========================================================
   // process-data watchdog
   fbio_pkg::wd_state_t wd_st_r, wd_st_nxt;
   logic [`WD_CNT_W-1:0] wd_cnt_r, wd_cnt_nxt;
   logic [`WD_CNT_W-1:0] wd_per_r, wd_per_nxt;

   // only out_wr_i retriggers; in_rd_i is deliberately ignored here
   always_comb
   begin
      wd_st_nxt = wd_st_r;
      wd_cnt_nxt = wd_cnt_r;
      wd_per_nxt = wd_per_r;
      unique case (wd_st_r)
         fbio_pkg::WD_OFF:
         begin
            if (prm_wd_en_i)
            begin
               wd_per_nxt = prm_wd_period_i;
               wd_st_nxt = fbio_pkg::WD_IDLE;
            end
         end
         fbio_pkg::WD_IDLE:
         begin
            if (out_wr_i)
            begin
               wd_cnt_nxt = wd_per_r;
               wd_st_nxt = fbio_pkg::WD_RUN;
            end
         end
         fbio_pkg::WD_RUN:
         begin
            if (out_wr_i)
               wd_cnt_nxt = wd_per_r;
            else if (wd_cnt_r <= `WD_CNT_ONE)
            begin
               wd_cnt_nxt = `WD_CNT_ZERO;
               wd_st_nxt = fbio_pkg::WD_EXPIRED;
            end
            else
               wd_cnt_nxt = wd_cnt_r - `WD_CNT_ONE;
         end
         fbio_pkg::WD_EXPIRED:
         begin
            // a fresh write recovers the link
            if (out_wr_i)
            begin
               wd_cnt_nxt = wd_per_r;
               wd_st_nxt = fbio_pkg::WD_RUN;
            end
         end
      endcase
      if (!prm_wd_en_i)
         wd_st_nxt = fbio_pkg::WD_OFF;
   end

   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wd_st_r <= fbio_pkg::WD_OFF;
         wd_cnt_r <= `WD_CNT_ZERO;
         wd_per_r <= `WD_CNT_ZERO;
      end
      else
      begin
         wd_st_r <= wd_st_nxt;
         wd_cnt_r <= wd_cnt_nxt;
         wd_per_r <= wd_per_nxt;
      end
   end

   // ==========================================================
   // output path: sync latch, then fallback selection
   logic [`CH_NUM-1:0] out_lat_r, out_lat_nxt;
   logic [`CH_NUM-1:0] pin_out_r, pin_out_nxt;
   logic fail;

   // outside sync mode writes pass straight into the latch
   always_comb
   begin
      out_lat_nxt = out_lat_r;
      if (sf_en_r)
      begin
         if (sync_cmd_i)
            out_lat_nxt = out_data_i;
      end
      else if (out_wr_i && out_valid_i)
         out_lat_nxt = out_data_i;
   end

   assign fail = (wd_st_r == fbio_pkg::WD_EXPIRED) || !comm_ok_i || !out_valid_i;

   // hold keeps what the pins already show
   always_comb
   begin
      pin_out_nxt = out_lat_r;
      if (fail)
      begin
         unique case (fbio_pkg::fallback_t'(mode_r))
            fbio_pkg::FB_ALL_LOW: pin_out_nxt = '0;
            fbio_pkg::FB_ALL_HIGH: pin_out_nxt = '1;
            fbio_pkg::FB_HOLD: pin_out_nxt = pin_out_r;
            fbio_pkg::FB_SUBST: pin_out_nxt = subst_r;
         endcase
      end
   end

   // ==========================================================
   // input path: freeze snapshot and output echo
   logic [`CH_NUM-1:0] frz_r, frz_nxt;
   logic [`CH_NUM-1:0] in_data_nxt;
   always_comb
   begin
      frz_nxt = frz_r;
      if (sf_en_r && freeze_cmd_i)
         frz_nxt = pin_in_i;
   end

   // output channels echo the driven level
   genvar c;
   generate
      for (c = 0; c < `CH_NUM; c++)
      begin : g_in
         assign in_data_nxt[c] = ch_is_out_i[c] ? pin_out_r[c] : (sf_en_r ? frz_r[c] : pin_in_i[c]);
      end
   endgenerate

   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_lat_r <= 16'h0000;
         pin_out_r <= 16'h0000;
         frz_r <= 16'h0000;
         in_data_o <= 16'h0000;
      end
      else
      begin
         out_lat_r <= out_lat_nxt;
         pin_out_r <= pin_out_nxt;
         frz_r <= frz_nxt;
         in_data_o <= in_data_nxt;
      end
   end
   assign pin_out_o = pin_out_r;

   // ==========================================================
   // diagnostics: entry per condition, alarm pulses on change
   logic [`DIAG_NUM-1:0] diag_r, diag_nxt;
   logic a_in_nxt, a_out_nxt, sf_nxt, bf_nxt;
   always_comb
   begin
      diag_nxt = diag_cond_i;
      a_in_nxt = alarm_en_r && |(diag_nxt & ~diag_r);
      a_out_nxt = alarm_en_r && |(~diag_nxt & diag_r);
      sf_nxt = |diag_nxt;
      bf_nxt = (wd_st_nxt == fbio_pkg::WD_EXPIRED) || !comm_ok_i;
   end

   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         diag_r <= '0;
         alarm_in_o <= 1'b0;
         alarm_out_o <= 1'b0;
         sum_fault_indicator_o <= 1'b0;
         bus_fault_indicator_o <= 1'b0;
      end
      else
      begin
         diag_r <= diag_nxt;
         alarm_in_o <= a_in_nxt;
         alarm_out_o <= a_out_nxt;
         sum_fault_indicator_o <= sf_nxt;
         bus_fault_indicator_o <= bf_nxt;
      end
   end

   // ==========================================================
   // identification records
   im_store_if im_bus();
   assign im_bus.rec_sel = im_rec_i;
   assign im_bus.addr = im_addr_i;
   assign im_bus.wr_en = im_wr_i && (im_rec_i != 2'h0); // record 0 is read only
   assign im_bus.wr_data = im_wdata_i;

   fbio_im_store u_store
   (
      .mclk_i(mclk_i),
      .rst_n(rst_n),
      .bus(im_bus.slave)
   );

   // record 0 laid out big-endian, 54 bytes
   logic [431:0] rec0;
   assign rec0 = {16'(`IM0_MAKER_CODE), CATALOGUE_NUMBER, UNIT_SERIAL, BOARD_REV, FIRMWARE_REV,
                  16'(`IM0_CHANGE_COUNT), 16'(`IM0_PROFILE_CODE), 16'(`IM0_PROFILE_SUBTYPE),
                  16'(`IM0_RECORD_VERSION), 16'(`IM0_RECORDS_PRESENT)};

   logic [7:0] rec0_byte;
   logic [7:0] rdata_nxt;
   always_comb
   begin
      rec0_byte = (im_addr_i < `IM_ADDR_W'(`IM_LEN_NOTE)) ? rec0[431 - 8 * int'(im_addr_i) -: 8] : 8'h00;
      rdata_nxt = (im_rec_i == 2'h0) ? rec0_byte : im_bus.rd_data;
   end

   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
         im_rdata_o <= 8'h00;
      else
         im_rdata_o <= rdata_nxt;
   end
endmodule : fbio_ctrl
`default_nettype wire

// ==== fbio_ctrl_assertions.sv ====
// port checker for the fieldbus i/o control block
// assumes a bind from the testbench and the single mclk_i domain
`timescale 1ns/1ps
`default_nettype none
module fbio_ctrl_assertions
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] prm_behavior_i,
   input wire logic [7:0] prm_subst_lo_i,
   input wire logic [7:0] prm_subst_hi_i,
   input wire logic prm_sync_freeze_en_i,
   input wire logic prm_wd_en_i,
   input wire logic [15:0] out_data_i,
   input wire logic out_wr_i,
   input wire logic out_valid_i,
   input wire logic comm_ok_i,
   input wire logic sync_cmd_i,
   input wire logic [15:0] pin_in_i,
   input wire logic [15:0] ch_is_out_i,
   input wire logic [4:0] diag_cond_i,
   input wire logic [15:0] pin_out_o,
   input wire logic [15:0] in_data_o,
   input wire logic alarm_in_o,
   input wire logic alarm_out_o,
   input wire logic sum_fault_indicator_o,
   input wire logic bus_fault_indicator_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // ==========================================
   // helpers
   logic [15:0] in_exp_r;
   logic [15:0] subst;
   logic [1:0] md;
   assign md = prm_behavior_i[1:0];
   assign subst = md == 2'h0 ? 16'h0000 : md == 2'h1 ? 16'hFFFF : {prm_subst_hi_i, prm_subst_lo_i};
   // output channels echo the pin they drive, inputs echo the pin, both one cycle late
   always_ff @(posedge mclk_i or negedge rst_n_i)
      if (!rst_n_i)
         in_exp_r <= 16'h0000;
      else
         in_exp_r <= (pin_out_o & ch_is_out_i) | (pin_in_i & ~ch_is_out_i);
   // ==========================================
   // properties
   property p_fault_on; (diag_cond_i != 5'h00) [*5] |-> sum_fault_indicator_o; endproperty
   a_fault_on: assert property (p_fault_on) else $error("fault indicator off");
   property p_fault_off; (diag_cond_i == 5'h00) [*5] |-> !sum_fault_indicator_o; endproperty
   a_fault_off: assert property (p_fault_off) else $error("fault indicator on");
   property p_alarm_in; alarm_in_o |-> ((($past(diag_cond_i) & ~$past(diag_cond_i, 2))
      | ($past(diag_cond_i, 2) & ~$past(diag_cond_i, 3))) != 5'h00) ##1 !alarm_in_o; endproperty
   a_alarm_in: assert property (p_alarm_in) else $error("stray incoming alarm");
   property p_alarm_out; alarm_out_o |-> (((~$past(diag_cond_i) & $past(diag_cond_i, 2))
      | (~$past(diag_cond_i, 2) & $past(diag_cond_i, 3))) != 5'h00) ##1 !alarm_out_o; endproperty
   a_alarm_out: assert property (p_alarm_out) else $error("stray outgoing alarm");
   property p_wr_direct; out_wr_i && out_valid_i && comm_ok_i && !prm_sync_freeze_en_i && !prm_wd_en_i
      ##1 comm_ok_i && out_valid_i |=> pin_out_o == $past(out_data_i, 2); endproperty
   a_wr_direct: assert property (p_wr_direct) else $error("write not on pins");
   // hold mode is left out: its value depends on history
   property p_fallback; (!comm_ok_i && md != 2'h2
      && $stable({prm_behavior_i, prm_subst_hi_i, prm_subst_lo_i})) [*4] |-> pin_out_o == subst; endproperty
   a_fallback: assert property (p_fallback) else $error("wrong fallback");
   property p_in_report; !prm_sync_freeze_en_i [*3] |-> in_data_o == in_exp_r; endproperty
   a_in_report: assert property (p_in_report) else $error("input data wrong");
   property p_sync_hold; (prm_sync_freeze_en_i && comm_ok_i && out_valid_i && !sync_cmd_i
      && !prm_wd_en_i) [*4] |-> $stable(pin_out_o); endproperty
   a_sync_hold: assert property (p_sync_hold) else $error("pins moved between syncs");
   property p_bf_rise; $rose(bus_fault_indicator_o) |-> !$past(comm_ok_i) || ($past(prm_wd_en_i, 2)
      && !$past(out_wr_i) && !$past(out_wr_i, 2)); endproperty
   a_bf_rise: assert property (p_bf_rise) else $error("bus fault too early");
   c_alarm: cover property (alarm_in_o ##[1:8] alarm_out_o);
   c_bf: cover property ($rose(bus_fault_indicator_o));
   c_sync: cover property (sync_cmd_i && prm_sync_freeze_en_i);
endmodule : fbio_ctrl_assertions
`default_nettype wire

// ==== fbio_master_model.sv ====
// bus master model: parameters, output writes, sync/freeze commands
// assumes the testbench calls its tasks; strobes last one mclk_i cycle
`timescale 1ns/1ps
`default_nettype none
module fbio_master_model
(
   input wire logic mclk_i,
   output var logic [7:0] beh_o,
   output var logic [7:0] lo_o,
   output var logic [7:0] hi_o,
   output var logic load_o,
   output var logic sf_o,
   output var logic ad_o,
   output var logic wden_o,
   output var logic [23:0] per_o,
   output var logic [15:0] data_o,
   output var logic wr_o,
   output var logic rd_o,
   output var logic valid_o,
   output var logic ok_o,
   output var logic sync_o,
   output var logic frz_o
);
   // link up and data valid from time zero
   initial
   begin
      {beh_o, lo_o, hi_o, load_o, sf_o, ad_o, wden_o, per_o, data_o, wr_o, rd_o, sync_o, frz_o} = '0;
      {valid_o, ok_o} = 2'h3;
   end
   // sync and freeze are only sent as meant once s was set by a load
   task load(input logic [7:0] b, l, h, input logic s, a);
      @(posedge mclk_i);
      {beh_o, lo_o, hi_o, sf_o, ad_o, load_o} <= {b, l, h, s, a, 1'b1};
      @(posedge mclk_i);
      load_o <= 1'b0;
   endtask : load
   // data stays after the strobe, as a real master's image does
   task wr(input logic [15:0] d);
      @(posedge mclk_i);
      {data_o, wr_o} <= {d, 1'b1};
      @(posedge mclk_i);
      wr_o <= 1'b0;
   endtask : wr
   task cmd(input logic s, f);
      @(posedge mclk_i);
      {sync_o, frz_o} <= {s, f};
      @(posedge mclk_i);
      {sync_o, frz_o} <= 2'h0;
   endtask : cmd
   task link(input logic o, v, r);
      @(posedge mclk_i);
      {ok_o, valid_o, rd_o} <= {o, v, r};
   endtask : link
   task wdog(input logic e, input logic [23:0] p);
      @(posedge mclk_i);
      {wden_o, per_o} <= {e, p};
   endtask : wdog
endmodule : fbio_master_model
`default_nettype wire

// ==== tb_fbio_ctrl.sv ====
// self-checking bench for the fieldbus i/o control block
// assumes the master model and the port checker beside it
`timescale 1ns/1ps
`default_nettype none
`include "fbio_regs.svh"
module tb_fbio_ctrl;
   logic mclk_i, rst_n_i, prm_load_i, prm_sync_freeze_en_i, prm_alarm_dis_i, prm_wd_en_i, out_wr_i;
   logic in_rd_i, out_valid_i, comm_ok_i, sync_cmd_i, freeze_cmd_i, im_wr_i, alarm_in_o, alarm_out_o;
   logic sum_fault_indicator_o, bus_fault_indicator_o, ai, ao;
   logic [7:0] prm_behavior_i, prm_subst_lo_i, prm_subst_hi_i, im_wdata_i, im_rdata_o, d;
   logic [23:0] prm_wd_period_i;
   logic [15:0] out_data_i, pin_in_i, ch_is_out_i, pin_out_o, in_data_o;
   logic [4:0] diag_cond_i;
   logic [1:0] im_rec_i;
   logic [5:0] im_addr_i;
   int miscompares = 0, tests_run = 0, cyc = 0;
   // identity values are arbitrary
   localparam logic [159:0] CAT = {5{32'h4A3B2C1D}};
   localparam logic [127:0] SER = {4{32'h9E8D7C6B}};
   localparam logic [15:0] BRD = 16'h5AA3;
   localparam logic [31:0] FW = 32'h01020304;
   localparam logic [431:0] IM0 = {`IM0_MAKER_CODE, CAT, SER, BRD, FW,
      16'h0000, 16'hF600, 16'h0003, 16'h0102, 16'h000E};
   fbio_ctrl #(.CATALOGUE_NUMBER(CAT), .UNIT_SERIAL(SER), .BOARD_REV(BRD), .FIRMWARE_REV(FW)) dut_u
      (.mclk_i, .rst_n_i, .prm_behavior_i, .prm_subst_lo_i, .prm_subst_hi_i, .prm_load_i,
      .prm_sync_freeze_en_i, .prm_alarm_dis_i, .prm_wd_en_i, .prm_wd_period_i, .out_data_i, .out_wr_i,
      .in_rd_i, .out_valid_i, .comm_ok_i, .sync_cmd_i, .freeze_cmd_i, .pin_in_i, .ch_is_out_i, .diag_cond_i,
      .im_rec_i, .im_addr_i, .im_wr_i, .im_wdata_i, .im_rdata_o, .pin_out_o, .in_data_o, .alarm_in_o,
      .alarm_out_o, .sum_fault_indicator_o, .bus_fault_indicator_o);
   fbio_master_model m_u (.mclk_i, .beh_o(prm_behavior_i), .lo_o(prm_subst_lo_i), .hi_o(prm_subst_hi_i),
      .load_o(prm_load_i), .sf_o(prm_sync_freeze_en_i), .ad_o(prm_alarm_dis_i), .wden_o(prm_wd_en_i),
      .per_o(prm_wd_period_i), .data_o(out_data_i), .wr_o(out_wr_i), .rd_o(in_rd_i),
      .valid_o(out_valid_i), .ok_o(comm_ok_i), .sync_o(sync_cmd_i), .frz_o(freeze_cmd_i));
   // ==========================================
   // tasks
   task chk(input logic [15:0] s, e);
      tests_run++;
      if (s !== e)
      begin
         miscompares++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
      end
   endtask : chk
   task end_of_test;
      if (miscompares == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   // waits n edges, then samples just after the last, gathering alarm pulses on the way
   task obs(input int n);
      ai = 1'b0;
      ao = 1'b0;
      repeat (n)
      begin
         @(posedge mclk_i);
         #1 ai = ai | alarm_in_o;
         ao = ao | alarm_out_o;
      end
   endtask : obs
   task rd(input logic [1:0] r, input logic [5:0] a);
      @(posedge mclk_i);
      {im_rec_i, im_addr_i} <= {r, a};
      obs(1);
      d = im_rdata_o;
   endtask : rd
   task imw(input logic [1:0] r, input logic [5:0] a, input logic [7:0] v);
      @(posedge mclk_i);
      {im_rec_i, im_addr_i, im_wdata_i, im_wr_i} <= {r, a, v, 1'b1};
      @(posedge mclk_i);
      im_wr_i <= 1'b0;
   endtask : imw
   // ==========================================
   // clock and cycle ceiling, far above the roughly seven hundred cycles needed
   initial
   begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         end_of_test;
      end
   end
   // ==========================================
   // main sequence
   initial
   begin
      {pin_in_i, ch_is_out_i, diag_cond_i, im_rec_i, im_addr_i, im_wr_i, im_wdata_i} = '0;
      rst_n_i = 1'b0;
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      obs(3);
      // every diagnostic source, before any load so the alarms are on by default
      for (int b = 0; b < 5; b++)
      begin
         @(posedge mclk_i);
         diag_cond_i <= 5'h01 << b;
         obs(5);
         chk({ai, sum_fault_indicator_o}, 2'h3);
         @(posedge mclk_i);
         diag_cond_i <= 5'h00;
         obs(5);
         chk({ao, sum_fault_indicator_o}, 2'h2);
      end
      m_u.load(8'h03, 8'h5A, 8'hC3, 1'b0, 1'b1);
      @(posedge mclk_i);
      diag_cond_i <= 5'h08;
      obs(5);
      chk(ai, 1'b0);
      @(posedge mclk_i);
      diag_cond_i <= 5'h00;
      for (int i = 0; i < 54; i++)
      begin
         rd(2'h0, i[5:0]);
         chk(d, IM0[431-8*i -: 8]);
      end
      imw(2'h0, 6'h2E, 8'h00);
      rd(2'h0, 6'h2E);
      chk(d, 8'hF6);
      for (int r = 1; r < 4; r++)
      begin
         for (int i = 0; i < 54; i++)
         begin
            rd(r[1:0], i[5:0]);
            chk(d, (r == 2 && i > 15) ? 8'h00 : 8'h20);
         end
         imw(r[1:0], 6'h35, {6'h28, r[1:0]});
         rd(r[1:0], 6'h35);
         chk(d, {6'h28, r[1:0]});
      end
      // hold first while the pins still show a written value, then the three forced modes
      m_u.load(8'h02, 8'h5A, 8'hC3, 1'b0, 1'b0);
      m_u.wr(16'h1234);
      @(posedge mclk_i);
      {ch_is_out_i, pin_in_i} <= {16'hFF00, 16'h00A5};
      obs(3);
      chk(in_data_o, 16'h12A5);
      m_u.link(1'b0, 1'b1, 1'b0);
      for (int k = 0; k < 4; k++)
      begin
         m_u.load({6'h00, k == 0 ? 2'h2 : k == 1 ? 2'h0 : k == 2 ? 2'h1 : 2'h3}, 8'h5A, 8'hC3, 1'b0, 1'b0);
         obs(4);
         chk(pin_out_o, k == 0 ? 16'h1234 : k == 1 ? 16'h0000 : k == 2 ? 16'hFFFF : 16'hC35A);
      end
      m_u.link(1'b1, 1'b0, 1'b0);
      m_u.wr(16'h7777);
      obs(4);
      chk(pin_out_o, 16'hC35A);
      m_u.link(1'b1, 1'b1, 1'b0);
      m_u.wr(16'h0F0F);
      obs(2);
      chk(pin_out_o, 16'h0F0F);
      // sync holds the pins, freeze holds the inputs
      m_u.load(8'h03, 8'h5A, 8'hC3, 1'b1, 1'b0);
      m_u.wr(16'hA55A);
      obs(3);
      chk(pin_out_o, 16'h0F0F);
      m_u.cmd(1'b1, 1'b0);
      obs(2);
      chk(pin_out_o, 16'hA55A);
      m_u.wr(16'h3C3C);
      obs(3);
      chk(pin_out_o, 16'hA55A);
      @(posedge mclk_i);
      {ch_is_out_i, pin_in_i} <= {16'h0000, 16'h6666};
      obs(3);
      m_u.cmd(1'b0, 1'b1);
      @(posedge mclk_i);
      pin_in_i <= 16'h9999;
      obs(3);
      chk(in_data_o, 16'h6666);
      m_u.cmd(1'b0, 1'b1);
      obs(3);
      chk(in_data_o, 16'h9999);
      m_u.load(8'h03, 8'h96, 8'h69, 1'b0, 1'b0);
      m_u.cmd(1'b0, 1'b1);
      @(posedge mclk_i);
      pin_in_i <= 16'h1111;
      obs(3);
      chk(in_data_o, 16'h1111);
      // watchdog of 20 cycles with reads running throughout
      m_u.wdog(1'b1, 24'h000014);
      m_u.link(1'b1, 1'b1, 1'b1);
      obs(30);
      chk(bus_fault_indicator_o, 1'b0);
      m_u.wr(16'h4242);
      obs(15);
      chk(bus_fault_indicator_o, 1'b0);
      m_u.wr(16'h4343);
      obs(15);
      chk({bus_fault_indicator_o, pin_out_o}, {1'b0, 16'h4343});
      obs(10);
      chk({bus_fault_indicator_o, pin_out_o}, {1'b1, 16'h6996});
      m_u.wr(16'h0101);
      obs(3);
      chk({bus_fault_indicator_o, pin_out_o}, {1'b0, 16'h0101});
      m_u.wdog(1'b0, 24'h000000);
      obs(3);
      end_of_test;
   end
endmodule : tb_fbio_ctrl
bind fbio_ctrl fbio_ctrl_assertions chk_u (.mclk_i, .rst_n_i, .prm_behavior_i, .prm_subst_lo_i,
   .prm_subst_hi_i, .prm_sync_freeze_en_i, .prm_wd_en_i, .out_data_i, .out_wr_i, .out_valid_i, .comm_ok_i,
   .sync_cmd_i, .pin_in_i, .ch_is_out_i, .diag_cond_i, .pin_out_o, .in_data_o, .alarm_in_o, .alarm_out_o,
   .sum_fault_indicator_o, .bus_fault_indicator_o);
`default_nettype wire
